/* File: logic/cpm_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// cpu power mode controller
// ==========================================================================
// How it works
// RULE_01: halt with select one enters Sleep
// RULE_02: halt with select zero enters Idle
// RULE_03: Normal clocks core and peripherals
// RULE_04: Idle stops core, keeps oscillator, peripherals
// RULE_05: any enabled interrupt wakes Idle
// RULE_06: Idle wake with interrupts enabled vectors first
// RULE_07: Idle wake without enable resumes next instruction
// RULE_08: reset pin low in Idle resets device
// RULE_09: Sleep stops oscillator, core and peripherals
// RULE_10: only wake pin exits Sleep, bit0 sensitivity
// RULE_11: warm-up then resume after Sleep wake
// RULE_12: reset pin low in Sleep resets device
// RULE_13: level mode needs pin low before halt
// RULE_14: edge mode sleeps even with pin high
// RULE_15: Sleep or disabled interrupts never vector
// RULE_16: register layout, bit2 one, bits7,3 zero
// RULE_17: register reachable only in bank zero
// RULE_18: watchdog timeout resets in every mode
// RULE_19: warm-up is parameter; aux field stored only
module cpm_top
    import cpm_pkg::*;
#(
    parameter int WARMUP_CYCLES = CPM_WARMUP_CYCLES
)(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // core register port
    input  wire logic [5:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    input  wire logic [7:0] status_register,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    // core control
    input  wire logic       halt_instruction,
    input  wire logic       global_irq_en,
    // interrupt and watchdog requests
    input  wire logic       irq_pending,
    input  wire logic       wdt_irq_req,
    input  wire logic       wdt_timeout,
    // pins
    input  wire logic       wake_pin_n,
    input  wire logic       dedicated_ext_irq_n,
    input  wire logic       ext_reset_n,
    // clock gating and sequencing
    output logic            osc_en,
    output logic            core_clk_en,
    output logic            periph_clk_en,
    output logic            irq_vector,
    output logic            resume_next,
    output logic            device_reset,
    output logic      [1:0] mode_code
);
    localparam int CW = $clog2(WARMUP_CYCLES + 1);
    localparam logic [CW-1:0] WARM_LAST = CW'(WARMUP_CYCLES - 1);

    cpm_wake_if wif ();

    cpm_wake_detect u_wake (
        .clk                 (clk),
        .rst                 (rst),
        .wake_pin_n          (wake_pin_n),
        .dedicated_ext_irq_n (dedicated_ext_irq_n),
        .ext_reset_n         (ext_reset_n),
        .w                   (wif.det)
    );

    // ======================================================================
    // mode control register
    // ======================================================================
    cpm_mode_t       state;
    cpm_mode_t       next_state;
    logic [2:0]      aux_field;
    logic            sleep_idle_select;
    logic            wake_sensitivity_select;
    logic [CW-1:0]   warm_cnt;

    wire reset_req  = wif.ext_rst_act | wdt_timeout;    // [RULE_08] [RULE_12] [RULE_18]
    wire bank_zero  = status_register[CPM_BANK_HI:CPM_BANK_LO]
                      == CPM_BANK_ZERO;                 // [RULE_17]
    wire reg_sel    = bank_zero & (reg_addr == CPM_MODE_REG_ADDR);
    wire reg_we     = reg_sel & reg_wr & ~reset_req;
    wire [7:0] reg_view = CPM_MODE_FIXED
                        | {1'b0, aux_field, 1'b0, 1'b0,
                           sleep_idle_select,
                           wake_sensitivity_select};    // [RULE_16]

    assign wif.wake_edge_sel = wake_sensitivity_select; // [RULE_10]

    // aux field has no effect here, it is only kept for software
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aux_field               <= CPM_AUX_RST;
            sleep_idle_select       <= CPM_SIS_RST;
            wake_sensitivity_select <= CPM_WSS_RST;
        end else if (reset_req) begin
            aux_field               <= CPM_AUX_RST;
            sleep_idle_select       <= CPM_SIS_RST;
            wake_sensitivity_select <= CPM_WSS_RST;
        end else if (reg_we) begin
            aux_field               <= reg_wdata[CPM_AUX_HI:CPM_AUX_LO]; // [RULE_19]
            sleep_idle_select       <= reg_wdata[CPM_SIS_BIT];
            wake_sensitivity_select <= reg_wdata[CPM_WSS_BIT];
        end
    end

    // read data comes one cycle after the strobe; outside bank 0 reads 0
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_hit   <= 1'b0;
        end else begin
            reg_hit   <= reg_sel & (reg_rd | reg_wr);
            reg_rdata <= (reg_sel & reg_rd) ? reg_view : 8'h00; // [RULE_17]
        end
    end

    // ======================================================================
    // mode sequencing
    // ======================================================================
    wire wake_idle  = irq_pending | wdt_irq_req | wif.ext_irq_act; // [RULE_05]
    wire warm_done  = (warm_cnt == WARM_LAST);

    always_comb begin
        next_state = state;
        case (state)
            CPM_NORMAL: begin
                if (halt_instruction) begin
                    next_state = sleep_idle_select ? CPM_SLEEP  // [RULE_01] [RULE_14]
                                                   : CPM_IDLE;  // [RULE_02]
                end
            end
            CPM_IDLE: begin
                if (wake_idle) begin
                    next_state = CPM_NORMAL;                    // [RULE_05]
                end
            end
            CPM_SLEEP: begin
                // interrupts are ignored here; only the wake pin or a reset request leaves
                if (wif.wake_event) begin
                    next_state = CPM_WARMUP;                    // [RULE_10] [RULE_15]
                end
            end
            CPM_WARMUP: begin
                if (warm_done) begin
                    next_state = CPM_NORMAL;                    // [RULE_11]
                end
            end
            default: begin
                next_state = CPM_NORMAL;
            end
        endcase
        if (reset_req) begin
            next_state = CPM_NORMAL;                // [RULE_08] [RULE_12] [RULE_18]
        end
    end

    wire idle_exit   = (state == CPM_IDLE) & wake_idle & ~reset_req;
    wire warm_exit   = (state == CPM_WARMUP) & warm_done & ~reset_req;
    wire normal_irq  = (state == CPM_NORMAL) & wake_idle & ~reset_req
                       & ~halt_instruction;
    wire next_vector = (idle_exit | normal_irq) & global_irq_en; // [RULE_06] [RULE_15]
    wire next_resume = (idle_exit & ~global_irq_en) | warm_exit; // [RULE_07] [RULE_11]
    wire next_core   = (next_state == CPM_NORMAL);               // [RULE_03]
    wire next_periph = (next_state == CPM_NORMAL)
                     | (next_state == CPM_IDLE);                 // [RULE_04]
    wire next_osc    = (next_state != CPM_SLEEP);                // [RULE_09]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= CPM_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // warm-up counts only while the oscillator settles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            warm_cnt <= '0;
        end else if (state == CPM_WARMUP && !warm_done) begin
            warm_cnt <= warm_cnt + CW'(1);                       // [RULE_11]
        end else begin
            warm_cnt <= '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_en        <= 1'b1;
            core_clk_en   <= 1'b1;
            periph_clk_en <= 1'b1;
            irq_vector    <= 1'b0;
            resume_next   <= 1'b0;
            device_reset  <= 1'b0;
        end else begin
            osc_en        <= next_osc;
            core_clk_en   <= next_core;
            periph_clk_en <= next_periph;
            irq_vector    <= next_vector;
            resume_next   <= next_resume;
            device_reset  <= reset_req;
        end
    end

    assign mode_code = state;

    // ======================================================================
    // checks
    // ======================================================================
    // independent age of the warm-up, so the length check does not lean
    // on the sequencing counter it is meant to judge
    localparam logic [CW-1:0] WARM_AGE_END = CW'(WARMUP_CYCLES);
    logic [CW-1:0] warm_age;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            warm_age <= '0;
        end else if (state == CPM_WARMUP) begin
            warm_age <= warm_age + CW'(1);
        end else begin
            warm_age <= '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_sleep_entry: assert property ( // [RULE_01]
        state == CPM_NORMAL && halt_instruction && sleep_idle_select
        && !reset_req |=> state == CPM_SLEEP ##0 !osc_en)
        else $error("halt with select one did not enter sleep");

    a_idle_entry: assert property ( // [RULE_02]
        state == CPM_NORMAL && halt_instruction && !sleep_idle_select
        && !reset_req |=> state == CPM_IDLE)
        else $error("halt with select zero did not enter idle");

    a_normal_clocks: assert property ( // [RULE_03]
        state == CPM_NORMAL |-> core_clk_en && periph_clk_en && osc_en)
        else $error("normal mode clocks not all running");

    a_idle_clocks: assert property ( // [RULE_04]
        state == CPM_IDLE |-> !core_clk_en && periph_clk_en && osc_en)
        else $error("idle mode clock gating wrong");

    a_idle_wake: assert property ( // [RULE_05]
        state == CPM_IDLE && wake_idle |=> state == CPM_NORMAL)
        else $error("idle did not leave on interrupt");

    a_idle_vector: assert property ( // [RULE_06]
        state == CPM_IDLE && wake_idle && global_irq_en && !reset_req
        |=> irq_vector && !resume_next && core_clk_en)
        else $error("idle wake with enable did not vector");

    a_idle_resume: assert property ( // [RULE_07]
        state == CPM_IDLE && wake_idle && !global_irq_en && !reset_req
        |=> resume_next && !irq_vector)
        else $error("idle wake without enable did not resume");

    a_reset_any: assert property ( // [RULE_08] [RULE_12] [RULE_18]
        reset_req |=> device_reset && state == CPM_NORMAL
        && !sleep_idle_select)
        else $error("reset request not honoured");

    a_sleep_clocks: assert property ( // [RULE_09]
        state == CPM_SLEEP |-> !osc_en && !core_clk_en && !periph_clk_en)
        else $error("sleep mode left a clock running");

    a_sleep_hold: assert property ( // [RULE_10] [RULE_15]
        state == CPM_SLEEP && !wif.wake_event && !reset_req
        |=> state == CPM_SLEEP && !irq_vector)
        else $error("sleep left without the wake pin");

    a_warm_len: assert property ( // [RULE_11]
        state == CPM_WARMUP && !reset_req
        |=> (warm_age == WARM_AGE_END)
            ? (state == CPM_NORMAL && resume_next)
            : (state == CPM_WARMUP && !core_clk_en && osc_en))
        else $error("warm-up length wrong");

    a_bank_gate: assert property ( // [RULE_17]
        reg_rd && !bank_zero |=> reg_rdata == 8'h00 && !reg_hit)
        else $error("register answered outside bank zero");

    a_fixed_bits: assert property ( // [RULE_16]
        reg_sel && reg_rd |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0
        && reg_rdata[2] == 1'b1)
        else $error("fixed register bits read wrong");

    a_no_vector: assert property ( // [RULE_15]
        !global_irq_en |=> !irq_vector)
        else $error("vector issued with interrupts disabled");

    c_sleep_wake: cover property (
        state == CPM_WARMUP ##1 state == CPM_NORMAL);
    c_idle_vector: cover property (
        state == CPM_IDLE ##1 irq_vector);
    c_reset_sleep: cover property (
        state == CPM_SLEEP && reset_req);
    c_edge_sleep: cover property (
        wake_sensitivity_select && state == CPM_SLEEP && wake_pin_n);

endmodule : cpm_top
`default_nettype wire

/* File: pkg/cpm_pkg.sv */
// ==========================================================================
// cpu power mode controller constants
// ==========================================================================
package cpm_pkg;

    // register port decode
    localparam logic [5:0] CPM_MODE_REG_ADDR = 6'h05;
    localparam int         CPM_BANK_HI       = 7;
    localparam int         CPM_BANK_LO       = 6;
    localparam logic [1:0] CPM_BANK_ZERO     = 2'h0;

    // mode control register fields
    localparam int         CPM_AUX_HI        = 6;
    localparam int         CPM_AUX_LO        = 4;
    localparam int         CPM_SIS_BIT       = 1;
    localparam int         CPM_WSS_BIT       = 0;
    localparam logic [2:0] CPM_AUX_RST       = 3'h0;
    localparam logic       CPM_SIS_RST       = 1'b0;
    localparam logic       CPM_WSS_RST       = 1'b0;
    localparam logic [7:0] CPM_MODE_FIXED    = 8'h04;

    // oscillator warm-up after a sleep wake, in oscillator cycles
    localparam int         CPM_WARMUP_CYCLES = 1024;

    typedef enum logic [1:0] {
        CPM_NORMAL,
        CPM_IDLE,
        CPM_SLEEP,
        CPM_WARMUP
    } cpm_mode_t;

endpackage : cpm_pkg

/* File: pkg/cpm_wake_if.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// pin conditioning results passed to the mode controller
// ==========================================================================
interface cpm_wake_if;
    logic wake_edge_sel;
    logic wake_event;
    logic ext_irq_act;
    logic ext_rst_act;

    modport det (
        input  wake_edge_sel,
        output wake_event,
        output ext_irq_act,
        output ext_rst_act
    );
    modport ctl (
        output wake_edge_sel,
        input  wake_event,
        input  ext_irq_act,
        input  ext_rst_act
    );
endinterface : cpm_wake_if
`default_nettype wire

/* File: logic/cpm_wake_detect.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// pin synchronisers and wake detection
// ==========================================================================
module cpm_wake_detect
    import cpm_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pins
    input  wire logic wake_pin_n,
    input  wire logic dedicated_ext_irq_n,
    input  wire logic ext_reset_n,
    // to controller
    cpm_wake_if.det   w
);
    logic [1:0] wake_sync;
    logic [1:0] irq_sync;
    logic [1:0] rst_sync;
    logic       wake_prev;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_sync <= 2'h3;
            irq_sync  <= 2'h3;
            rst_sync  <= 2'h3;
            wake_prev <= 1'b1;
        end else begin
            wake_sync <= {wake_sync[0], wake_pin_n};
            irq_sync  <= {irq_sync[0], dedicated_ext_irq_n};
            rst_sync  <= {rst_sync[0], ext_reset_n};
            wake_prev <= wake_sync[1];
        end
    end

    // level mode: pin held low keeps sleep, high wakes; edge mode wakes
    // on the rising edge so sleep may start with the pin already high
    wire wake_rise  = wake_sync[1] & ~wake_prev;
    wire wake_level = wake_sync[1];

    assign w.wake_event  = w.wake_edge_sel ? wake_rise : wake_level;
    assign w.ext_irq_act = ~irq_sync[1];
    assign w.ext_rst_act = ~rst_sync[1];

endmodule : cpm_wake_detect
`default_nettype wire

/* File: testbench/cpm_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// board side of the wake and interrupt pins
// ==========================================
module cpm_far_model (
    // clock
    input  wire logic clk,
    // requests from the bench
    input  wire logic sleep_release,
    input  wire logic irq_assert,
    // pins, pulled high when idle
    output logic      wake_pin_n,
    output logic      dedicated_ext_irq_n
);
    initial begin
        wake_pin_n          = 1'b1;
        dedicated_ext_irq_n = 1'b1;
    end
    // pins move just after the edge that carried the request
    always @(posedge clk) begin
        wake_pin_n          <= #1 sleep_release;
        dedicated_ext_irq_n <= #1 !irq_assert;
    end
endmodule : cpm_far_model
`default_nettype wire

/* File: testbench/cpm_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// mode controller testbench
// ==========================================
module cpm_top_tb
    import cpm_pkg::*;
;
    // short warm-up keeps the run brief
    localparam int   W = 4;
    localparam logic [5:0] A = CPM_MODE_REG_ADDR;
    logic       clk, rst, reg_wr, reg_rd, halt_instruction, global_irq_en;
    logic       irq_pending, wdt_irq_req, wdt_timeout, ext_reset_n;
    logic       sleep_release, irq_assert, wake_pin_n, ext_irq_n;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, status_register, reg_rdata, d;
    logic       reg_hit, osc_en, core_clk_en, periph_clk_en, h;
    logic       irq_vector, resume_next, device_reset;
    logic [1:0] mode_code;
    int         failures, samples_checked, n;

    cpm_top #(.WARMUP_CYCLES(W)) u_dut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .status_register(status_register), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .halt_instruction(halt_instruction),
        .global_irq_en(global_irq_en), .irq_pending(irq_pending),
        .wdt_irq_req(wdt_irq_req), .wdt_timeout(wdt_timeout),
        .wake_pin_n(wake_pin_n), .dedicated_ext_irq_n(ext_irq_n),
        .ext_reset_n(ext_reset_n), .osc_en(osc_en),
        .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
        .irq_vector(irq_vector), .resume_next(resume_next),
        .device_reset(device_reset), .mode_code(mode_code));
    cpm_far_model u_far (.clk(clk), .sleep_release(sleep_release),
        .irq_assert(irq_assert), .wake_pin_n(wake_pin_n),
        .dedicated_ext_irq_n(ext_irq_n));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ==========================================
    // helpers
    // ==========================================
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic check(input string what, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [7:0] en();
        return {5'h0, osc_en, core_clk_en, periph_clk_en};
    endfunction : en
    function automatic logic [7:0] md();
        return {6'h0, mode_code};
    endfunction : md
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        step();
        reg_rd = 1'b0;
        d = reg_rdata;
        h = reg_hit;
        // one idle edge so a following read does not re-raise the strobe
        step();
    endtask : rd
    task automatic halt();
        halt_instruction = 1'b1;
        step();
        halt_instruction = 1'b0;
    endtask : halt
    // waits are bounded so a stuck mode cannot hang the run
    task automatic wait_mode(input logic [1:0] m, input int lim);
        n = 0;
        while (mode_code !== m && n < lim) begin
            step();
            n++;
        end
    endtask : wait_mode
    task automatic wait_rst();
        n = 0;
        while (device_reset !== 1'b1 && n < 8) begin
            step();
            n++;
        end
    endtask : wait_rst
    // ==========================================
    // scenarios
    // ==========================================
    task automatic t_regs();
        rd(A);
        check("reset value", d, CPM_MODE_FIXED);
        check("hit", {7'h0, h}, 8'h01);
        wr(A, 8'hFF);
        rd(A);
        check("fields", d, 8'h77);
        status_register = 8'h40;
        wr(A, 8'h00);
        rd(A);
        check("bank1 read", d, 8'h00);
        status_register = 8'h00;
        rd(6'h06);
        check("unmapped hit", {7'h0, h}, 8'h00);
        rd(A);
        check("bank1 write", d, 8'h77);
        $display("test regs done");
    endtask : t_regs
    task automatic t_idle();
        wr(A, 8'h00);
        check("normal clocks", en(), 8'h07);
        halt();
        check("idle mode", md(), 8'h01);
        check("idle clocks", en(), 8'h05);
        global_irq_en = 1'b1;
        irq_pending = 1'b1;
        step();
        irq_pending = 1'b0;
        global_irq_en = 1'b0;
        check("irq wake", md(), 8'h00);
        check("vector", {irq_vector, resume_next}, 8'h02);
        halt();
        wdt_irq_req = 1'b1;
        step();
        wdt_irq_req = 1'b0;
        check("wdt wake", md(), 8'h00);
        check("resume", {irq_vector, resume_next}, 8'h01);
        halt();
        irq_assert = 1'b1;
        wait_mode(2'h0, 8);
        irq_assert = 1'b0;
        check("pin wake", {irq_vector, resume_next}, 8'h01);
        repeat (4) step();
        $display("test idle done");
    endtask : t_idle
    task automatic t_sleep(input logic edge_mode);
        wr(A, {7'h01, edge_mode});
        halt();
        check("sleep mode", md(), 8'h02);
        check("sleep clocks", en(), 8'h00);
        global_irq_en = 1'b1;
        irq_pending = 1'b1;
        wdt_irq_req = 1'b1;
        irq_assert = 1'b1;
        repeat (6) step();
        check("irq in sleep", md(), 8'h02);
        check("no vector", {7'h0, irq_vector}, 8'h00);
        irq_pending = 1'b0;
        wdt_irq_req = 1'b0;
        irq_assert = 1'b0;
        global_irq_en = 1'b0;
        // pin held low: no level wake, and only a falling edge in edge mode
        sleep_release = 1'b0;
        repeat (6) step();
        check("no wake", md(), 8'h02);
        sleep_release = 1'b1;
        wait_mode(2'h3, 8);
        check("warm-up", md(), 8'h03);
        check("warm clocks", en(), 8'h04);
        wait_mode(2'h0, W + 4);
        check("warm length", n[7:0], W[7:0]);
        check("resume", {7'h0, resume_next}, 8'h01);
        check("woken clocks", en(), 8'h07);
        $display("test sleep done");
    endtask : t_sleep
    task automatic t_resets();
        wr(A, 8'h70);
        halt();
        ext_reset_n = 1'b0;
        wait_rst();
        check("idle reset", {device_reset, 5'h0, mode_code}, 8'h80);
        ext_reset_n = 1'b1;
        sleep_release = 1'b0;
        repeat (4) step();
        rd(A);
        check("cleared", d, CPM_MODE_FIXED);
        wr(A, 8'h02);
        halt();
        ext_reset_n = 1'b0;
        wait_rst();
        check("sleep reset", {device_reset, 5'h0, mode_code}, 8'h80);
        ext_reset_n = 1'b1;
        repeat (4) step();
        wr(A, 8'h02);
        halt();
        wdt_timeout = 1'b1;
        wait_rst();
        wdt_timeout = 1'b0;
        check("wdt reset", {device_reset, 5'h0, mode_code}, 8'h80);
        sleep_release = 1'b1;
        repeat (4) step();
        $display("test resets done");
    endtask : t_resets
    task automatic t_normal_irq();
        irq_pending = 1'b1;
        step();
        check("masked", {7'h0, irq_vector}, 8'h00);
        global_irq_en = 1'b1;
        step();
        irq_pending = 1'b0;
        global_irq_en = 1'b0;
        check("normal vector", {7'h0, irq_vector}, 8'h01);
        step();
        $display("test normal irq done");
    endtask : t_normal_irq
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        #20000;
        failures++;
        summarize();
    end
    initial begin
        failures = 0;
        samples_checked = 0;
        rst = 1'b1;
        {reg_wr, reg_rd, halt_instruction, global_irq_en} = 4'h0;
        {irq_pending, wdt_irq_req, wdt_timeout, irq_assert} = 4'h0;
        ext_reset_n = 1'b1;
        sleep_release = 1'b1;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        status_register = 8'h00;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        t_regs();
        t_idle();
        sleep_release = 1'b0;
        repeat (3) step();
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_resets();
        t_normal_irq();
        summarize();
    end
endmodule : cpm_top_tb
`default_nettype wire
